/* File: bgs_pkg.sv */
// Constants and types for the buck gate sequencer
// Functional notes
// R1: Fixed 600 kHz internal switching oscillator
// R2: Low side waits for switch-node fall
// R3: High side waits for low-gate fall
// R4: Watchdog forces low side if node stuck
// R5: Reference ramps linearly to 0.8 V, 4.5 ms
// R6: Pre-charged output shortens soft-start under 4 ms
// R7: Undervoltage armed only after soft-start
// R8: Soft-start waits supply-good and threshold acquisition
// R9: Low side masked until high side switches
// R10: Low side enabled at soft-start end anyway
// R11: Masking applies only to loop requests
// R12: Overcurrent compared only while low side on
// R13: Four consecutive first-level events trip
// R14: Second-level event trips immediately
// R15: Overcurrent latches both switches off
// R16: Threshold acquisition lasts about 5 ms
// R17: Undervoltage latches both switches off
// R18: Overvoltage: high off, low follows 0.4 V
// R19: Power-good at soft-start end, window gated
// R20: Overcurrent counter clears on clean cycle
// R21: Watchdog interval is a cycle parameter
`default_nettype none
package bgs_pkg;
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned SW_HZ         = 600_000;
    localparam int unsigned PERIOD_CYC    = CLK_HZ / SW_HZ;
    localparam int unsigned MAX_ON_CYC    = (PERIOD_CYC * 2) / 3;
    localparam int unsigned SS_TIME_US    = 4500;
    localparam int unsigned SS_CYC        = SS_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OCSET_TIME_US = 5000;
    localparam int unsigned OCSET_CYC     = OCSET_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WDOG_SW_CYC   = 1;
    localparam int unsigned OC_TRIP_COUNT = 4;
    localparam int unsigned REF_W         = 12;
    localparam logic [REF_W-1:0] REF_FINAL = 12'h800;
    localparam logic [2:0]  OC_CNT_RST    = 3'h0;

    typedef enum logic [1:0] {
        BGS_OCSET,
        BGS_SOFT,
        BGS_RUN,
        BGS_OFF
    } bgs_phase_t;

    typedef enum logic [1:0] {
        BGS_DEAD_LO,
        BGS_HIGH_ON,
        BGS_DEAD_HI,
        BGS_LOW_ON
    } bgs_gate_t;

    typedef struct packed {
        logic high_side_switch;
        logic low_side_switch;
    } bgs_drive_t;

    typedef struct packed {
        logic oc_first;
        logic oc_second;
        logic under;
        logic over;
        logic above_release;
        logic in_window;
    } bgs_sense_t;
endpackage
`default_nettype wire

/* File: bgs_osc.sv */
// Switching-cycle oscillator: phase count and cycle-start pulse
`default_nettype none
module bgs_osc
    import bgs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    output logic [8:0]       phase_o,
    output logic             cycle_start_o
);
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;

    always_comb
    begin
        if (cnt_reg == 9'(PERIOD_CYC - 1))
            cnt_next = 9'h000;
        else
            cnt_next = cnt_reg + 9'h001;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cnt_reg <= 9'h000;
        else
            cnt_reg <= cnt_next; // [R1]
    end

    assign phase_o       = cnt_reg;
    assign cycle_start_o = (cnt_reg == 9'h000);

    property p_period;
        @(posedge clk_i) disable iff (!nrst_i)
        cycle_start_o |=> !cycle_start_o [*8];
    endproperty
    a_period: assert property (p_period) else $error("cycle start too close"); // [R1]
endmodule
`default_nettype wire

/* File: bgs_core.sv */
// Buck gate sequencer with soft-start and latched protections
`default_nettype none
module bgs_core
    import bgs_pkg::*;
#(
    parameter int unsigned SS_CYCLES    = SS_CYC,
    parameter int unsigned OCSET_CYCLES = OCSET_CYC,
    parameter int unsigned WDOG_CYCLES  = WDOG_SW_CYC
)
(
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             pwm_request_i,
    input  wire logic             switch_node_low_i,
    input  wire logic             low_gate_low_i,
    input  wire bgs_sense_t       sense_i,
    output bgs_drive_t            drive_o,
    output logic [REF_W-1:0]      reference_o,
    output logic                  supply_ok_flag_o,
    output logic                  fault_latched_o
);
    logic [8:0]  phase;
    logic        cycle_start;

    bgs_osc u_osc
    (
        .clk_i         (clk_i),
        .nrst_i        (nrst_i),
        .phase_o       (phase),
        .cycle_start_o (cycle_start)
    );

    bgs_phase_t  ph_reg,    ph_next;
    bgs_gate_t   gt_reg,    gt_next;
    logic [31:0] tmr_reg,   tmr_next;
    logic [REF_W-1:0] ref_reg, ref_next;
    logic [2:0]  occ_reg,   occ_next;
    logic        oc1_cyc_reg, oc1_cyc_next;
    logic        hs_seen_reg, hs_seen_next;
    logic        ovp_reg,   ovp_next;
    logic        pg_reg,    pg_next;
    logic [31:0] wd_reg,    wd_next;
    logic        hs_reg,    hs_next;
    logic        ls_reg,    ls_next;
    logic        oc_trip,   uv_trip, ls_loop_ok, want_high, ovp_ls;

    // Clamp on-time so the bootstrap still refreshes
    assign want_high = pwm_request_i && (phase < 9'(MAX_ON_CYC));
    assign oc_trip   = ls_reg && (sense_i.oc_second // [R12] [R14]
                     || (sense_i.oc_first && occ_reg == 3'(OC_TRIP_COUNT - 1))); // [R13]
    assign uv_trip   = (ph_reg == BGS_RUN) && sense_i.under; // [R7] [R17]
    assign ls_loop_ok = (ph_reg == BGS_RUN) || hs_seen_reg; // [R9] [R10]
    assign ovp_ls    = ovp_reg && sense_i.above_release; // [R18]

    always_comb
    begin
        ph_next      = ph_reg;
        tmr_next     = tmr_reg + 32'h1;
        ref_next     = ref_reg;
        occ_next     = occ_reg;
        oc1_cyc_next = oc1_cyc_reg || (ls_reg && sense_i.oc_first);
        hs_seen_next = hs_seen_reg;
        ovp_next     = ovp_reg || (sense_i.over && ph_reg != BGS_OCSET); // [R18]
        pg_next      = pg_reg;
        case (ph_reg)
            BGS_OCSET:
            begin
                if (tmr_reg >= OCSET_CYCLES - 1) // [R8] [R16]
                begin
                    ph_next  = BGS_SOFT;
                    tmr_next = 32'h0;
                end
            end
            BGS_SOFT:
            begin
                // Linear ramp; pre-charged output ends early when it reaches target [R5] [R6]
                ref_next = REF_W'((64'(tmr_reg) * REF_FINAL) / SS_CYCLES);
                if (hs_reg)
                    hs_seen_next = 1'b1;
                // Early end at 7/8 of the ramp keeps a pre-charged start under 4 ms
                if (tmr_reg >= SS_CYCLES - 1 || (hs_seen_reg && !sense_i.under
                        && sense_i.in_window && tmr_reg >= (SS_CYCLES * 7) / 8))
                begin
                    ph_next  = BGS_RUN;
                    ref_next = REF_FINAL;
                    pg_next  = 1'b1; // [R19]
                end
            end
            BGS_RUN:
            begin
                tmr_next = tmr_reg;
                pg_next  = sense_i.in_window && !ovp_reg; // [R19]
            end
            default:
            begin
                tmr_next = tmr_reg;
                pg_next  = 1'b0;
            end
        endcase
        if (cycle_start)
        begin
            // Counter tracks consecutive cycles; a boundary hit counts for the ending cycle
            occ_next = oc1_cyc_next ? occ_reg + 3'h1 : OC_CNT_RST; // [R20]
            oc1_cyc_next = 1'b0;
        end
        if (oc_trip || uv_trip)
        begin
            ph_next = BGS_OFF; // [R15] [R17]
            pg_next = 1'b0;
        end
    end

    // Gate sequencing with adaptive dead time
    always_comb
    begin
        gt_next = gt_reg;
        wd_next = 32'h0;
        hs_next = 1'b0;
        ls_next = 1'b0;
        case (gt_reg)
            BGS_DEAD_LO:
            begin
                // Idle loop parks on the low side once the node is down [R2] [R10]
                if (want_high && low_gate_low_i && !ovp_reg) // [R3]
                    gt_next = BGS_HIGH_ON;
                else if (!want_high && switch_node_low_i)
                    gt_next = BGS_LOW_ON;
            end
            BGS_HIGH_ON:
            begin
                hs_next = want_high && !ovp_reg;
                if (!want_high || ovp_reg)
                begin
                    gt_next = BGS_DEAD_HI;
                    hs_next = 1'b0;
                end
            end
            BGS_DEAD_HI:
            begin
                wd_next = wd_reg + 32'h1;
                // Node stuck high on negative current: watchdog takes over [R4] [R21]
                if (switch_node_low_i || wd_reg >= WDOG_CYCLES * PERIOD_CYC - 1) // [R2]
                    gt_next = BGS_LOW_ON;
            end
            default:
            begin
                ls_next = 1'b1;
                if (want_high)
                begin
                    gt_next = BGS_DEAD_LO;
                    ls_next = 1'b0;
                end
            end
        endcase
        if (ph_reg != BGS_SOFT && ph_reg != BGS_RUN)
        begin
            hs_next = 1'b0; // [R15]
            ls_next = 1'b0;
            gt_next = BGS_DEAD_LO;
        end
        else if (gt_next == BGS_LOW_ON && !ls_loop_ok)
            ls_next = 1'b0; // [R9] [R11]
        if (ovp_reg)
        begin
            hs_next = 1'b0;
            ls_next = ovp_ls; // [R11] [R18]
        end
        if (oc_trip || uv_trip)
        begin
            hs_next = 1'b0;
            ls_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ph_reg      <= BGS_OCSET;
            gt_reg      <= BGS_DEAD_LO;
            tmr_reg     <= 32'h0;
            ref_reg     <= '0;
            occ_reg     <= OC_CNT_RST;
            oc1_cyc_reg <= 1'b0;
            hs_seen_reg <= 1'b0;
            ovp_reg     <= 1'b0;
            pg_reg      <= 1'b0;
            wd_reg      <= 32'h0;
            hs_reg      <= 1'b0;
            ls_reg      <= 1'b0;
        end
        else
        begin
            ph_reg      <= ph_next;
            gt_reg      <= gt_next;
            tmr_reg     <= tmr_next;
            ref_reg     <= ref_next;
            occ_reg     <= occ_next;
            oc1_cyc_reg <= oc1_cyc_next;
            hs_seen_reg <= hs_seen_next;
            ovp_reg     <= ovp_next;
            pg_reg      <= pg_next;
            wd_reg      <= wd_next;
            hs_reg      <= hs_next;
            ls_reg      <= ls_next;
        end
    end

    assign drive_o.high_side_switch = hs_reg;
    assign drive_o.low_side_switch  = ls_reg;
    assign reference_o              = ref_reg;
    assign supply_ok_flag_o         = pg_reg;
    assign fault_latched_o          = (ph_reg == BGS_OFF) || ovp_reg;

    property p_no_overlap;
        @(posedge clk_i) disable iff (!nrst_i)
        !(hs_reg && ls_reg);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("shoot-through"); // [R2]

    property p_hs_after_lgate;
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(hs_reg) |-> $past(low_gate_low_i);
    endproperty
    a_hs_after_lgate: assert property (p_hs_after_lgate) else $error("high early"); // [R3]

    property p_wdog;
        @(posedge clk_i) disable iff (!nrst_i)
        (gt_reg == BGS_DEAD_HI && wd_reg == WDOG_CYCLES * PERIOD_CYC - 1)
            |=> gt_reg == BGS_LOW_ON;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog missed"); // [R4]

    property p_ss_wait;
        @(posedge clk_i) disable iff (!nrst_i)
        ph_reg == BGS_OCSET |-> !hs_reg && !ls_reg;
    endproperty
    a_ss_wait: assert property (p_ss_wait) else $error("switching before start"); // [R8]

    property p_mask;
        @(posedge clk_i) disable iff (!nrst_i)
        (ph_reg == BGS_SOFT && !hs_seen_reg && !ovp_reg) |=> !ls_reg;
    endproperty
    a_mask: assert property (p_mask) else $error("low side unmasked"); // [R9]

    property p_oc2;
        @(posedge clk_i) disable iff (!nrst_i)
        (ls_reg && sense_i.oc_second) |=> ph_reg == BGS_OFF && !hs_reg && !ls_reg;
    endproperty
    a_oc2: assert property (p_oc2) else $error("second level missed"); // [R14]

    property p_latch;
        @(posedge clk_i) disable iff (!nrst_i)
        ph_reg == BGS_OFF |=> ph_reg == BGS_OFF && !hs_reg;
    endproperty
    a_latch: assert property (p_latch) else $error("latch released"); // [R15]

    property p_uv_arm;
        @(posedge clk_i) disable iff (!nrst_i)
        (ph_reg == BGS_SOFT && sense_i.under) |=> ph_reg != BGS_OFF || $past(oc_trip);
    endproperty
    a_uv_arm: assert property (p_uv_arm) else $error("undervoltage armed early"); // [R7]

    property p_ovp;
        @(posedge clk_i) disable iff (!nrst_i)
        ovp_reg |=> !hs_reg;
    endproperty
    a_ovp: assert property (p_ovp) else $error("high on in overvoltage"); // [R18]

    property p_pg;
        @(posedge clk_i) disable iff (!nrst_i)
        (ph_reg == BGS_SOFT && $past(ph_reg) == BGS_SOFT) |-> !pg_reg;
    endproperty
    a_pg: assert property (p_pg) else $error("power-good early"); // [R19]
endmodule
`default_nettype wire

/* File: bgs_switch_model.sv */
// Behavioural model of the external high-side and low-side power switches
`default_nettype none
module bgs_switch_model
    import bgs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire bgs_drive_t drive_i,
    input  wire logic       stuck_i,
    output logic            switch_node_low_o,
    output logic            low_gate_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hs_hist = 2'h0;
    logic       lg_hist = 1'b0;
    // Node sags two cycles after turn-off; negative current holds it up
    always_ff @(posedge clk_i)
    begin
        hs_hist <= {hs_hist[0], drive_i.high_side_switch};
        lg_hist <= drive_i.low_side_switch;
    end
    assign switch_node_low_o = !stuck_i && (hs_hist == 2'h0) && !drive_i.high_side_switch;
    // Gate discharge seen one cycle after the command drops
    assign low_gate_low_o    = !lg_hist && !drive_i.low_side_switch;
endmodule
`default_nettype wire

/* File: buck_gate_sequencer_protect_test.sv */
// Self-checking bench for the buck gate sequencer
`default_nettype none
module buck_gate_sequencer_protect_test
    import bgs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SS = 900;
    localparam int OC = 500;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic             pwm = 1'b0;
    logic             stuck = 1'b0;
    logic             node_low;
    logic             lg_low;
    bgs_sense_t       sns = '0;
    bgs_drive_t       drv;
    logic [REF_W-1:0] ref_v;
    logic             pg;
    logic             flt;
    logic             seen_hs;
    logic             seen_ls;
    logic             bad_seq;
    logic             p_hs;
    logic             p_ls;
    logic             p_node;
    logic             p_lg;
    int               err_count = 0;
    int               compares = 0;
    int               cyc = 0;

    bgs_core #(.SS_CYCLES(SS), .OCSET_CYCLES(OC), .WDOG_CYCLES(1)) u_bgs_core (
        .clk_i(clk), .nrst_i(nrst), .pwm_request_i(pwm), .switch_node_low_i(node_low),
        .low_gate_low_i(lg_low), .sense_i(sns), .drive_o(drv), .reference_o(ref_v),
        .supply_ok_flag_o(pg), .fault_latched_o(flt));
    bgs_switch_model u_bgs_switch_model (
        .clk_i(clk), .drive_i(drv), .stuck_i(stuck),
        .switch_node_low_o(node_low), .low_gate_low_o(lg_low));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Ceiling well above the seven start-ups the scenarios need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %b seen %b", name, exp, got);
            err_count++;
        end
    endtask

    task automatic run(input int n);
        repeat (n)
        begin
            p_hs = drv.high_side_switch;
            p_ls = drv.low_side_switch;
            p_node = node_low;
            p_lg = lg_low;
            @(posedge clk);
            #1;
            seen_hs |= drv.high_side_switch;
            seen_ls |= drv.low_side_switch;
            bad_seq |= drv.high_side_switch && drv.low_side_switch;
            bad_seq |= drv.high_side_switch && !p_hs && !p_lg;
            bad_seq |= !stuck && drv.low_side_switch && !p_ls && !p_node;
        end
    endtask

    task automatic wait_for(input logic hs, input logic v);
        int n;
        n = 0;
        while (((hs ? drv.high_side_switch : drv.low_side_switch) !== v) && n < 800)
        begin
            run(1);
            n++;
        end
        chk("wait_drive", 1'b1, n < 800);
    endtask

    // Supply removal is the only way out of a latched fault
    task automatic start_up(input logic want);
        nrst = 1'b0;
        sns = '0;
        stuck = 1'b0;
        pwm = want;
        run(4);
        nrst = 1'b1;
        seen_hs = 1'b0;
        seen_ls = 1'b0;
        bad_seq = 1'b0;
    endtask

    // Output pre-biased above target: loop asks for no high side until soft-start has ended
    task automatic t_soft();
        int t0;
        start_up(1'b0);
        run(OC - 10);
        chk("ref_acq", 1'b1, ref_v === '0);
        run(10 + SS / 2);
        chk("ref_mid", 1'b1, ref_v > 12'h300 && ref_v < 12'h500);
        run(SS / 2 - 40);
        chk("ref_ramp", 1'b0, ref_v === REF_FINAL);
        chk("pg_early", 1'b0, pg);
        chk("ls_masked", 1'b0, seen_ls);
        run(60);
        chk("ref_final", 1'b1, ref_v === REF_FINAL);
        chk("ls_at_end", 1'b1, drv.low_side_switch);
        sns.in_window = 1'b1;
        run(3);
        chk("pg_set", 1'b1, pg);
        sns.in_window = 1'b0;
        pwm = 1'b1;
        seen_hs = 1'b0;
        run(3);
        chk("pg_drop", 1'b0, pg);
        run(700);
        chk("still_switching", 1'b1, seen_hs);
        chk("dead_time", 1'b0, bad_seq);
        wait_for(1'b1, 1'b0);
        wait_for(1'b1, 1'b1);
        t0 = cyc;
        wait_for(1'b1, 1'b0);
        wait_for(1'b1, 1'b1);
        chk("period", 1'b1, cyc - t0 == PERIOD_CYC);
    endtask

    task automatic t_precharged();
        start_up(1'b1);
        sns.in_window = 1'b1;
        run(OC + SS - 40);
        chk("pg_short", 1'b1, pg);
    endtask

    task automatic t_watchdog();
        start_up(1'b1);
        run(OC + SS + 60);
        stuck = 1'b1;
        wait_for(1'b1, 1'b1);
        pwm = 1'b0;
        wait_for(1'b1, 1'b0);
        run(250);
        chk("ls_waits_node", 1'b0, drv.low_side_switch);
        wait_for(1'b0, 1'b1);
    endtask

    task automatic cycles(input int n, input logic v);
        wait_for(1'b0, 1'b0);
        sns.oc_first = v;
        repeat (n)
        begin
            wait_for(1'b0, 1'b1);
            wait_for(1'b0, 1'b0);
        end
    endtask

    task automatic t_oc();
        start_up(1'b1);
        run(OC + SS + 60);
        cycles(3, 1'b1);
        cycles(1, 1'b0);
        cycles(3, 1'b1);
        chk("oc_three", 1'b0, flt);
        cycles(1, 1'b1);
        run(3);
        chk("oc_four", 1'b1, flt);
        seen_hs = 1'b0;
        seen_ls = 1'b0;
        run(700);
        chk("oc_latched", 1'b0, seen_hs || seen_ls);
        start_up(1'b1);
        run(OC + SS + 60);
        wait_for(1'b1, 1'b1);
        sns.oc_second = 1'b1;
        run(20);
        chk("oc2_high_on", 1'b0, flt);
        sns.oc_second = 1'b0;
        wait_for(1'b0, 1'b1);
        sns.oc_second = 1'b1;
        run(3);
        chk("oc2_trip", 1'b1, flt);
        chk("oc2_off", 1'b0, drv.low_side_switch || drv.high_side_switch);
    endtask

    task automatic t_uv();
        start_up(1'b1);
        run(OC + SS / 2);
        sns.under = 1'b1;
        run(20);
        chk("uv_in_soft", 1'b0, flt);
        sns.under = 1'b0;
        run(SS / 2 + 60);
        sns.under = 1'b1;
        run(3);
        chk("uv_trip", 1'b1, flt);
        chk("uv_off", 1'b0, drv.low_side_switch || drv.high_side_switch);
    endtask

    // Overvoltage inside soft-start, while the loop still masks the low side
    task automatic t_ov();
        start_up(1'b0);
        run(OC + 100);
        sns.over = 1'b1;
        sns.above_release = 1'b1;
        run(3);
        chk("ov_ls_on", 1'b1, drv.low_side_switch);
        chk("ov_latch", 1'b1, flt);
        sns.above_release = 1'b0;
        sns.over = 1'b0;
        run(3);
        chk("ov_release", 1'b0, drv.low_side_switch);
        sns.above_release = 1'b1;
        pwm = 1'b1;
        seen_hs = 1'b0;
        run(3);
        chk("ov_reenable", 1'b1, drv.low_side_switch);
        run(700);
        chk("ov_hs_off", 1'b0, seen_hs);
    endtask

    initial
    begin
        t_soft();
        t_precharged();
        t_watchdog();
        t_oc();
        t_uv();
        t_ov();
        give_verdict();
    end
endmodule
`default_nettype wire
